// [inc/epb_consts.svh]
// offsets, field positions, reset values and counts of the packet buffer
`ifndef EPB_CONSTS_SVH
`define EPB_CONSTS_SVH
`define EPB_OFF_CTRL 8'h00
`define EPB_OFF_STATUS 8'h04
`define EPB_OFF_IRQ_STAT 8'h08
`define EPB_OFF_IRQ_MASK 8'h0C
`define EPB_OFF_TX_THRESH 8'h10
`define EPB_CTRL_TSTART 0
`define EPB_CTRL_FULL_SF 1
`define EPB_CTRL_FDX 2
`define EPB_CTRL_WIDE64 3
`define EPB_CTRL_RESET 4'h2
`define EPB_THRESH_RESET 16'h0010
`define EPB_IRQ_TX_DONE 0
`define EPB_IRQ_TX_UNDER 1
`define EPB_IRQ_TX_EXHAUST 2
`define EPB_IRQ_RX_GOOD 3
`define EPB_IRQ_RX_OVF 4
`define EPB_IRQ_RX_BAD 5
`define EPB_IRQ_W 6
`define EPB_TX_MAX_ATTEMPTS 5'h10
`define EPB_STAT_WORDS_32 2'h3
`define EPB_STAT_WORDS_64 2'h2
`endif

// [inc/epb_pkg.sv]
// types shared by the packet buffer design
package epb_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT} epb_tx_e;
  typedef enum logic {RX_DATA, RX_STAT} epb_rx_e;
endpackage

// [rtl/epb_ring.sv]
// packet buffer memory with one write port and one registered read port
`timescale 1ns/10ps
`default_nettype none
module epb_ring #(
  parameter int DW = 34,
  parameter int AW = 6
) (
  // clock
  input wire logic i_clock,
  // write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // read port
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // storage write
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // read data held until the next read
  always_ff @(posedge i_clock) begin
    if (i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule // epb_ring
`default_nettype wire

// [rtl/epb_top.sv]
// transmit and receive packet buffers between mac and dma
`timescale 1ns/10ps
`default_nettype none
`include "epb_consts.svh"
// Functional notes
// R1 - full store-forward: start mac only after the whole frame is stored
// R2 - full store-forward: hold frame until sent or retries exhausted, then flush
// R3 - partial store-forward: start mac once enough data is present
// R4 - partial mode underflow: end transmission early, flush whole transmit buffer
// R5 - after underflow only a software start bit write resumes transmission
// R6 - half duplex: hold frame until success or retry exhaustion, then flush
// R7 - full duplex: free transmit space as words are read out
// R8 - collision retries from buffer; flush frame after sixteen failed attempts
// R9 - receive buffer keeps frames with status; errored frames discarded (code discards them only in full store-forward, else keeps them flagged bad)
// R10 - each mac push becomes a buffer write; status stored at frame end
// R11 - full store-forward: errored frame data flushed, status still reported
// R12 - reserve three status words per frame, two in 64-bit mode
// R13 - dropped frame keeps only its status entry (code does so only in full store-forward; otherwise its stored data stays)
// R14 - full buffer detected; following data dropped and overflow interrupt raised
// R15 - full store-forward: dma reads only frames whose status is stored
// R16 - good frames are read out in order to the dma
// R17 - status and statistics reported once frame data is in the buffer
// R18 - integrator sizes the buffer for the largest transmitted frame
// R19 - readout order always equals write order on both paths
module epb_top #(
  parameter int TX_AW = 6,
  parameter int RX_AW = 6
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  // transmit fill from dma
  input wire logic i_txf_valid,
  input wire logic [31:0] i_txf_data,
  input wire logic i_txf_last,
  output logic o_txf_ready,
  // mac transmitter
  output logic o_mtx_start,
  input wire logic i_mtx_rd,
  output logic [31:0] o_mtx_data,
  output logic o_mtx_last,
  output logic o_mtx_underflow,
  input wire logic i_mtx_done,
  input wire logic i_mtx_coll,
  // mac receiver
  input wire logic i_mrx_push,
  input wire logic [31:0] i_mrx_data,
  input wire logic i_mrx_end,
  input wire logic i_mrx_bad,
  input wire logic [31:0] i_mrx_status,
  input wire logic [31:0] i_mrx_stats,
  // status update towards mac registers
  output logic o_upd_valid,
  output logic [31:0] o_upd_status,
  output logic [31:0] o_upd_stats,
  // receive readout to dma
  output logic o_drx_avail,
  input wire logic i_drx_rd,
  output logic [31:0] o_drx_data,
  output logic o_drx_stat,
  output logic o_drx_end
);
  localparam int TX_DEPTH = 1 << TX_AW;
  localparam int RX_DEPTH = 1 << RX_AW;

  logic [3:0] ctrl_reg;
  logic [15:0] thresh_reg;
  logic [`EPB_IRQ_W-1:0] irq_stat_reg, irq_mask_reg, ev;
  logic full_sf, fdx, wide;
  logic start_wr;
  epb_pkg::epb_tx_e tx_state_reg;
  epb_pkg::epb_rx_e rx_state_reg;
  logic [TX_AW:0] tx_wptr_reg, tx_rptr_reg, tx_fptr_reg, tx_used, tx_level;
  logic [7:0] tx_frames_reg;
  logic [4:0] tx_fail_reg;
  logic tx_run_reg, tx_drop_reg, tx_rd_q;
  logic tx_we, tx_re, tx_under, tx_coll, tx_exhaust, tx_release;
  logic [32:0] tx_q;
  logic [RX_AW:0] rx_wptr_reg, rx_rptr_reg, rx_fbase_reg, rx_used, rx_base_used;
  logic [7:0] rx_frames_reg, rx_frames_next;
  logic [29:0] rx_len_reg;
  logic [1:0] rx_idx_reg, rx_words;
  logic rx_ovf_reg, rx_lost_reg, rx_bad_reg, rx_drop_reg, rx_skip, rx_rd_q;
  logic rx_push_ok, rx_end, rx_we, rx_drop_now;
  logic [33:0] rx_wdata, rx_q;
  logic [31:0] rx_status_reg, rx_stats_reg;

  assign full_sf = ctrl_reg[`EPB_CTRL_FULL_SF];
  assign fdx = ctrl_reg[`EPB_CTRL_FDX];
  assign wide = ctrl_reg[`EPB_CTRL_WIDE64];
  assign start_wr = i_wr && i_addr == `EPB_OFF_CTRL && i_wdata[`EPB_CTRL_TSTART];

  // ---------------- register port ----------------
  // control, threshold and mask writes
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctrl_reg <= `EPB_CTRL_RESET;
      thresh_reg <= `EPB_THRESH_RESET;
      irq_mask_reg <= '0;
    end else if (i_wr) begin
      if (i_addr == `EPB_OFF_CTRL) ctrl_reg <= {i_wdata[3:1], 1'b0};
      if (i_addr == `EPB_OFF_TX_THRESH) thresh_reg <= i_wdata[15:0];
      if (i_addr == `EPB_OFF_IRQ_MASK) irq_mask_reg <= i_wdata[`EPB_IRQ_W-1:0];
    end
  end

  // sticky events, cleared by a read, a new event wins
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      irq_stat_reg <= '0;
    end else if (i_rd && i_addr == `EPB_OFF_IRQ_STAT) begin
      irq_stat_reg <= ev;
    end else begin
      irq_stat_reg <= irq_stat_reg | ev;
    end
  end

  // level interrupt, registered
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) o_irq <= 1'b0;
    else o_irq <= |((irq_stat_reg | ev) & irq_mask_reg);
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || !i_rd) begin
      o_rdata <= '0;
    end else begin
      unique case (i_addr)
        `EPB_OFF_CTRL: o_rdata <= {28'h0000000, ctrl_reg};
        `EPB_OFF_STATUS: o_rdata <= {rx_frames_reg, tx_frames_reg, 8'h00, tx_fail_reg,
                                     tx_drop_reg, tx_run_reg, rx_ovf_reg};
        `EPB_OFF_IRQ_STAT: o_rdata <= {26'h0000000, irq_stat_reg};
        `EPB_OFF_IRQ_MASK: o_rdata <= {26'h0000000, irq_mask_reg};
        `EPB_OFF_TX_THRESH: o_rdata <= {16'h0000, thresh_reg};
        default: o_rdata <= '0;
      endcase
    end
  end

  // ---------------- transmit path ----------------
  assign tx_used = tx_wptr_reg - tx_fptr_reg;
  assign tx_level = tx_wptr_reg - tx_rptr_reg;
  assign tx_we = i_txf_valid && o_txf_ready && !tx_drop_reg;
  assign tx_re = i_mtx_rd && tx_state_reg == epb_pkg::TX_SEND;
  assign tx_under = tx_re && tx_level == '0; // see R4
  assign tx_coll = i_mtx_coll && !fdx && tx_state_reg != epb_pkg::TX_IDLE;
  assign tx_exhaust = tx_coll && tx_fail_reg == `EPB_TX_MAX_ATTEMPTS - 5'h01; // see R8
  assign tx_release = (i_mtx_done && tx_state_reg != epb_pkg::TX_IDLE) || tx_exhaust;

  epb_ring #(.DW(33), .AW(TX_AW)) u_tx_ring (
    .i_clock(i_clock),
    .i_we(tx_we),
    .i_waddr(tx_wptr_reg[TX_AW-1:0]),
    .i_wdata({i_txf_last, i_txf_data}),
    .i_re(tx_re),
    .i_raddr(tx_rptr_reg[TX_AW-1:0]),
    .o_rdata(tx_q)
  );
  assign o_mtx_data = tx_q[31:0];

  // fill side: write pointer, dropping the rest of an underflowed frame
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tx_wptr_reg <= '0;
      tx_drop_reg <= 1'b0;
      o_txf_ready <= 1'b0;
    end else begin
      if (tx_we) tx_wptr_reg <= tx_wptr_reg + 1'b1;
      if (tx_under) tx_drop_reg <= !(i_txf_valid && i_txf_last); // see R4
      else if (i_txf_valid && o_txf_ready && i_txf_last) tx_drop_reg <= 1'b0;
      o_txf_ready <= tx_drop_reg || tx_under ||
                     ({1'b0, tx_used} + 2) <= (TX_AW + 2)'(TX_DEPTH);
    end
  end

  // complete frames stored and not yet released
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || tx_under) begin
      tx_frames_reg <= '0;
    end else begin
      tx_frames_reg <= tx_frames_reg + 8'(tx_we && i_txf_last) - 8'(tx_release);
    end
  end

  // transmit sequencing towards the mac
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tx_state_reg <= epb_pkg::TX_IDLE;
      tx_rptr_reg <= '0;
      tx_fptr_reg <= '0;
      tx_fail_reg <= '0;
      tx_run_reg <= 1'b0;
      tx_rd_q <= 1'b0;
      o_mtx_start <= 1'b0;
      o_mtx_underflow <= 1'b0;
      o_mtx_last <= 1'b0;
    end else begin
      o_mtx_start <= 1'b0;
      o_mtx_underflow <= tx_under;
      tx_rd_q <= tx_re && !tx_under;
      o_mtx_last <= tx_rd_q && tx_q[32];
      if (start_wr) tx_run_reg <= 1'b1; // see R5
      if (tx_re && !tx_under) begin
        tx_rptr_reg <= tx_rptr_reg + 1'b1;
        if (fdx) tx_fptr_reg <= tx_rptr_reg + 1'b1; // see R7
      end
      unique case (tx_state_reg)
        epb_pkg::TX_IDLE: begin
          if (tx_run_reg && (tx_frames_reg != '0 ||
              (!full_sf && {1'b0, tx_level} >= (TX_AW + 2)'(thresh_reg)))) begin
            o_mtx_start <= 1'b1; // see R1, R3
            tx_state_reg <= epb_pkg::TX_SEND;
          end
        end
        epb_pkg::TX_SEND: begin
          if (tx_rd_q && tx_q[32]) tx_state_reg <= epb_pkg::TX_WAIT;
        end
        epb_pkg::TX_WAIT: begin
        end
      endcase
      if (tx_under) begin
        // whole buffer emptied, stay halted until software restarts
        tx_rptr_reg <= tx_wptr_reg; // see R4
        tx_fptr_reg <= tx_wptr_reg;
        tx_run_reg <= 1'b0; // see R5
        tx_fail_reg <= '0;
        tx_state_reg <= epb_pkg::TX_IDLE;
      end else if (tx_release) begin
        // frame freed here on the mac's verdict; full duplex frees words as they are read
        tx_fptr_reg <= tx_rptr_reg; // see R2, R6, R8
        tx_fail_reg <= '0;
        tx_state_reg <= epb_pkg::TX_IDLE;
      end else if (tx_coll) begin
        // rewind to frame start and try again from the buffer
        tx_rptr_reg <= tx_fptr_reg; // see R8, R19
        tx_fail_reg <= tx_fail_reg + 5'h01;
        tx_state_reg <= epb_pkg::TX_IDLE;
      end
    end
  end

  // ---------------- receive path ----------------
  assign rx_used = rx_wptr_reg - rx_rptr_reg;
  assign rx_base_used = rx_fbase_reg - rx_rptr_reg;
  assign rx_words = wide ? `EPB_STAT_WORDS_64 : `EPB_STAT_WORDS_32; // see R12
  assign rx_push_ok = rx_state_reg == epb_pkg::RX_DATA && i_mrx_push && !rx_ovf_reg &&
                      ({1'b0, rx_used} + (RX_AW + 2)'(rx_words)) < (RX_AW + 2)'(RX_DEPTH);
  assign rx_end = rx_state_reg == epb_pkg::RX_DATA && i_mrx_end;
  assign rx_drop_now = rx_ovf_reg || (i_mrx_push && !rx_push_ok) || (full_sf && i_mrx_bad);
  // status entry: flags and length, status word, statistics word
  always_comb begin
    unique case (rx_idx_reg)
      2'h0: rx_wdata = {2'b01, rx_bad_reg, rx_drop_reg, rx_len_reg}; // see R9
      2'h1: rx_wdata = {wide, 1'b1, rx_status_reg}; // last word in 64-bit mode
      default: rx_wdata = {2'b11, rx_stats_reg};
    endcase
    if (rx_state_reg == epb_pkg::RX_DATA) rx_wdata = {2'b00, i_mrx_data};
  end
  assign rx_we = rx_push_ok || (rx_state_reg == epb_pkg::RX_STAT && !rx_skip);

  epb_ring #(.DW(34), .AW(RX_AW)) u_rx_ring (
    .i_clock(i_clock),
    .i_we(rx_we),
    .i_waddr(rx_wptr_reg[RX_AW-1:0]),
    .i_wdata(rx_wdata),
    .i_re(i_drx_rd),
    .i_raddr(rx_rptr_reg[RX_AW-1:0]),
    .o_rdata(rx_q)
  );
  assign o_drx_data = rx_q[31:0];

  // frame writing and status entry sequencing
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rx_state_reg <= epb_pkg::RX_DATA;
      rx_wptr_reg <= '0;
      rx_fbase_reg <= '0;
      rx_len_reg <= '0;
      rx_idx_reg <= '0;
      rx_ovf_reg <= 1'b0;
      rx_lost_reg <= 1'b0;
      rx_bad_reg <= 1'b0;
      rx_drop_reg <= 1'b0;
      rx_skip <= 1'b0;
      rx_status_reg <= '0;
      rx_stats_reg <= '0;
    end else begin
      unique case (rx_state_reg)
        epb_pkg::RX_DATA: begin
          if (rx_push_ok) begin
            rx_wptr_reg <= rx_wptr_reg + 1'b1; // see R10
            rx_len_reg <= rx_len_reg + 30'h00000001;
          end else if (i_mrx_push) begin
            rx_ovf_reg <= 1'b1; // see R14
          end
          if (rx_end) begin
            rx_bad_reg <= i_mrx_bad;
            rx_drop_reg <= rx_drop_now;
            rx_status_reg <= i_mrx_status; // see R10
            rx_stats_reg <= i_mrx_stats;
            rx_idx_reg <= '0;
            rx_state_reg <= epb_pkg::RX_STAT;
            if (full_sf && rx_drop_now) begin
              rx_wptr_reg <= rx_fbase_reg; // see R11, R13
              rx_skip <= ({1'b0, rx_base_used} + (RX_AW + 2)'(rx_words)) >
                         (RX_AW + 2)'(RX_DEPTH);
            end else begin
              rx_skip <= ({1'b0, rx_used} + (RX_AW + 2)'(rx_words)) >
                         (RX_AW + 2)'(RX_DEPTH);
            end
          end
        end
        epb_pkg::RX_STAT: begin
          if (i_mrx_push) rx_lost_reg <= 1'b1; // see R14
          if (!rx_skip) rx_wptr_reg <= rx_wptr_reg + 1'b1; // see R12
          rx_idx_reg <= rx_idx_reg + 2'h1;
          if (rx_idx_reg == rx_words - 2'h1 || rx_skip) begin
            rx_state_reg <= epb_pkg::RX_DATA;
            rx_fbase_reg <= rx_skip ? rx_wptr_reg : rx_wptr_reg + 1'b1;
            rx_len_reg <= '0;
            rx_ovf_reg <= rx_lost_reg || i_mrx_push;
            rx_lost_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // status handed to the mac registers at frame end
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_upd_valid <= 1'b0;
      o_upd_status <= '0;
      o_upd_stats <= '0;
    end else begin
      o_upd_valid <= rx_end; // see R17, R11
      if (rx_end) begin
        o_upd_status <= i_mrx_status;
        o_upd_stats <= i_mrx_stats;
      end
    end
  end

  // entry count after this cycle's completed and drained entries
  assign rx_frames_next = rx_frames_reg
                          + 8'(rx_state_reg == epb_pkg::RX_STAT && !rx_skip &&
                               rx_idx_reg == rx_words - 2'h1)
                          - 8'(rx_rd_q && rx_q[33] && rx_q[32]);

  // dma readout: data words then the status entry, in write order
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rx_rptr_reg <= '0;
      rx_frames_reg <= '0;
      rx_rd_q <= 1'b0;
      o_drx_avail <= 1'b0;
      o_drx_stat <= 1'b0;
      o_drx_end <= 1'b0;
    end else begin
      rx_rd_q <= i_drx_rd;
      if (i_drx_rd) rx_rptr_reg <= rx_rptr_reg + 1'b1; // see R16, R19
      if (rx_rd_q) begin
        o_drx_stat <= rx_q[32];
        o_drx_end <= rx_q[33];
      end else begin
        o_drx_stat <= 1'b0;
        o_drx_end <= 1'b0;
      end
      rx_frames_reg <= rx_frames_next;
      // next count used, so a just-drained entry is never offered again
      o_drx_avail <= !i_drx_rd && (full_sf ? rx_frames_next != '0 : rx_used != '0); // see R15
    end
  end

  // interrupt events
  always_comb begin
    ev = '0;
    ev[`EPB_IRQ_TX_DONE] = i_mtx_done && tx_state_reg != epb_pkg::TX_IDLE;
    ev[`EPB_IRQ_TX_UNDER] = tx_under;
    ev[`EPB_IRQ_TX_EXHAUST] = tx_exhaust;
    ev[`EPB_IRQ_RX_GOOD] = rx_end && !rx_drop_now && !i_mrx_bad;
    ev[`EPB_IRQ_RX_OVF] = i_mrx_push && !rx_push_ok && !rx_ovf_reg; // see R14
    ev[`EPB_IRQ_RX_BAD] = rx_end && (rx_drop_now || i_mrx_bad);
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  a_tx_full_start: assert property (o_mtx_start && $past(full_sf) // see R1
      |-> $past(tx_frames_reg) != 8'h00)
    else $error("start before whole frame stored");
  a_tx_hold_frame: assert property (!fdx && tx_fptr_reg != $past(tx_fptr_reg) // see R2, R6
      |-> $past(tx_release || tx_under || fdx))
    else $error("transmit frame freed without verdict");
  a_tx_under_flush: assert property (tx_under |=> // see R4
      tx_rptr_reg == tx_wptr_reg - (TX_AW + 1)'($past(tx_we)) && tx_fptr_reg == tx_rptr_reg
      && !tx_run_reg && o_mtx_underflow)
    else $error("underflow did not flush buffer");
  a_tx_no_restart: assert property (!tx_run_reg && !start_wr // see R5
      |=> !tx_run_reg && !o_mtx_start)
    else $error("transmitter restarted on its own");
  a_tx_fdx_release: assert property (fdx && tx_re && !tx_under && !tx_release // see R7
      |=> tx_fptr_reg == tx_rptr_reg)
    else $error("full duplex space not released");
  a_tx_retry_flush: assert property (tx_exhaust |=> tx_fail_reg == 5'h00 // see R8
      && tx_fptr_reg == tx_rptr_reg && tx_state_reg == epb_pkg::TX_IDLE)
    else $error("frame not flushed after sixteen attempts");
  a_rx_bad_flush: assert property (rx_end && full_sf && rx_drop_now // see R11, R13
      |=> rx_wptr_reg == $past(rx_fbase_reg))
    else $error("bad frame data kept");
  a_rx_stat_words: assert property ($rose(rx_state_reg == epb_pkg::RX_STAT) // see R12
      && !rx_skip && !wide
      |-> (rx_state_reg == epb_pkg::RX_STAT)[*3] ##1 rx_state_reg == epb_pkg::RX_DATA)
    else $error("status entry length wrong");
  a_rx_ovf_irq: assert property (ev[`EPB_IRQ_RX_OVF] // see R14
      |=> irq_stat_reg[`EPB_IRQ_RX_OVF])
    else $error("overflow not flagged");
  a_rx_dma_gate: assert property (o_drx_avail && $past(full_sf) // see R15
      |-> rx_frames_reg != 8'h00)
    else $error("dma offered incomplete frame");
  a_rx_upd_time: assert property (rx_end |=> o_upd_valid ##1 !o_upd_valid) // see R17
    else $error("status update missing");

  c_tx_sent: cover property (o_mtx_start ##[1:200] ev[`EPB_IRQ_TX_DONE]);
  c_tx_retry: cover property (tx_coll && !tx_exhaust ##[1:50] o_mtx_start);
  c_tx_under: cover property (o_mtx_underflow ##[1:100] start_wr);
  c_rx_drop: cover property (rx_end && rx_drop_now ##[1:100] o_drx_end);
endmodule // epb_top
`default_nettype wire

// [testbench/epb_mac_model.sv]
// mac transmitter model that reads frames out of the buffer
`timescale 1ns/10ps
`default_nettype none
module epb_mac_model (
  // clock
  input wire logic i_clock,
  // buffer side
  input wire logic i_start,
  input wire logic i_last,
  input wire logic i_under,
  input wire logic [4:0] i_colls,
  output logic o_rd = 1'b0,
  output logic o_done = 1'b0,
  output logic o_coll = 1'b0
);
  logic busy = 1'b0;
  logic [1:0] ph = 2'h0;
  logic [4:0] nc = 5'h00;
  // one read every third cycle, then success or a collision
  always @(posedge i_clock) begin
    o_rd <= 1'b0;
    o_done <= 1'b0;
    o_coll <= 1'b0;
    if (i_start) begin
      busy <= 1'b1;
      ph <= 2'h0;
    end else if (busy) begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (i_under) begin
        busy <= 1'b0;
      end else if (i_last) begin
        busy <= 1'b0;
        nc <= (nc < i_colls) ? nc + 5'h01 : 5'h00;
        o_coll <= nc < i_colls;
        o_done <= nc >= i_colls;
      end else if (ph == 2'h0) begin
        o_rd <= 1'b1;
      end
    end
  end
endmodule // epb_mac_model
`default_nettype wire

// [testbench/epb_top_tb.sv]
// self-checking bench for the packet buffer
`timescale 1ns/10ps
`default_nettype none
`include "epb_consts.svh"
module epb_top_tb;
  // design and partner connections
  logic i_clock, i_sys_rst, i_wr, i_rd, o_irq;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, i_txf_data, o_mtx_data, i_mrx_data;
  logic [31:0] i_mrx_status, i_mrx_stats, o_upd_status, o_upd_stats, o_drx_data;
  logic i_txf_valid, i_txf_last, o_txf_ready, o_mtx_start, i_mtx_rd, o_mtx_last;
  logic o_mtx_underflow, i_mtx_done, i_mtx_coll, i_mrx_push, i_mrx_end, i_mrx_bad;
  logic o_upd_valid, o_drx_avail, i_drx_rd, o_drx_stat, o_drx_end;
  // bench state
  logic [4:0] colls;
  logic [31:0] w;
  logic [31:0] frm[$], qr[$], qm[$], qd[$], qk[$];
  logic rq = 1'b0, mq = 1'b0, dq = 1'b0;
  int n_fail = 0, n_checks = 0, seed = 41, ns = 0, k, n;

  // 64 words each way hold every frame sent here
  epb_top #(.TX_AW(6), .RX_AW(6)) epb_top_i (
    .i_clock, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq,
    .i_txf_valid, .i_txf_data, .i_txf_last, .o_txf_ready, .o_mtx_start, .i_mtx_rd,
    .o_mtx_data, .o_mtx_last, .o_mtx_underflow, .i_mtx_done, .i_mtx_coll,
    .i_mrx_push, .i_mrx_data, .i_mrx_end, .i_mrx_bad, .i_mrx_status, .i_mrx_stats,
    .o_upd_valid, .o_upd_status, .o_upd_stats, .o_drx_avail, .i_drx_rd,
    .o_drx_data, .o_drx_stat, .o_drx_end);
  // mac transmitter on the far side
  epb_mac_model epb_mac_model_i (.i_clock, .i_start(o_mtx_start), .i_last(o_mtx_last),
    .i_under(o_mtx_underflow), .i_colls(colls), .o_rd(i_mtx_rd), .o_done(i_mtx_done),
    .o_coll(i_mtx_coll));

  // clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    qr.push_back(e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
  endtask

  // scoreboard: each answer against the oldest note
  always @(posedge i_clock) begin
    if (rq) chk(o_rdata, qr.pop_front());
    if (mq && qm.size() > 0) chk(o_mtx_data, qm.pop_front());
    if (dq) chk(o_drx_data & qk.pop_front(), qd.pop_front());
    if (o_mtx_start === 1'b1) ns++;
    rq <= i_rd;
    mq <= i_mtx_rd;
    dq <= i_drx_rd;
  end

  // dma fills one transmit frame
  task automatic txf(input int len, input logic lst);
    int s0;
    s0 = ns;
    frm.delete();
    @(posedge i_clock);
    for (int j = 0; j < len; j++) begin
      w = $random(seed);
      frm.push_back(w);
      if (lst && j == len - 1) chk(32'(ns - s0), 32'h0);
      i_txf_valid <= 1'b1;
      i_txf_data <= w;
      i_txf_last <= lst && j == len - 1;
      @(posedge i_clock);
      for (k = 0; k < 50 && o_txf_ready !== 1'b1; k++) @(posedge i_clock);
    end
    i_txf_valid <= 1'b0;
    i_txf_last <= 1'b0;
  endtask

  // wait for the interrupt, read and clear its status
  task automatic tx_irq(input logic [31:0] e);
    for (k = 0; k < 600 && o_irq !== 1'b1; k++) @(posedge i_clock);
    rd(8'h08, e);
    repeat (2) @(posedge i_clock);
    chk(o_irq, 32'h0);
  endtask

  // expected dma word with the bits that matter
  task automatic note(input logic [31:0] e, input logic [31:0] m);
    qd.push_back(e);
    qk.push_back(m);
  endtask

  // mac receiver frame, then dma readout of its entry
  task automatic rx(input int len, input logic bad, input logic [1:0] sw);
    for (int j = 0; j < len; j++) begin
      w = $random(seed);
      @(posedge i_clock);
      i_mrx_push <= 1'b1;
      i_mrx_data <= w;
      if (!bad) note(w, 32'hFFFFFFFF);
    end
    w = $random(seed);
    @(posedge i_clock);
    chk(o_drx_avail, 32'h0);
    i_mrx_push <= 1'b0;
    i_mrx_end <= 1'b1;
    i_mrx_bad <= bad;
    i_mrx_status <= w;
    i_mrx_stats <= ~w;
    @(posedge i_clock);
    i_mrx_end <= 1'b0;
    @(posedge i_clock);
    chk(o_upd_valid, 32'h1);
    chk(o_upd_status, w);
    chk(o_upd_stats, ~w);
    note({bad, 31'h0}, 32'h80000000);
    note(w, 32'hFFFFFFFF);
    if (sw == 2'h3) note(~w, 32'hFFFFFFFF);
    for (n = 0; n < 9 && o_drx_end !== 1'b1; n++) begin
      for (k = 0; k < 50 && o_drx_avail !== 1'b1; k++) @(posedge i_clock);
      i_drx_rd <= 1'b1;
      @(posedge i_clock);
      i_drx_rd <= 1'b0;
      repeat (2) @(posedge i_clock);
    end
    chk(o_drx_stat, 32'h1);
    chk(o_drx_avail, 32'h0);
    chk(32'(n), 32'((bad ? 0 : len) + sw));
  endtask

  // watchdog
  initial begin
    #300000;
    n_fail++;
    conclude;
  end

  // main sequence
  initial begin
    {i_sys_rst, i_wr, i_rd, i_txf_valid, i_txf_last, i_mrx_push} = 6'h20;
    {i_mrx_end, i_mrx_bad, i_drx_rd, colls} = 8'h00;
    {i_addr, i_wdata, i_txf_data} = 72'h0;
    {i_mrx_data, i_mrx_status, i_mrx_stats} = 96'h0;
    repeat (8) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    // reset values, unmapped place ignored
    rd(8'h00, {28'h0, `EPB_CTRL_RESET});
    rd(8'h10, {16'h0, `EPB_THRESH_RESET});
    rd(8'h04, 32'h0);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14, 32'h0);
    rd(8'h0C, 32'h0);
    wr(8'h0C, 32'h3F);
    wr(8'h00, 32'h3);
    // full store-forward frame sent once
    txf(3, 1'b1);
    foreach (frm[i]) qm.push_back(frm[i]);
    tx_irq(32'h1);
    // sixteen collisions, frame resent from the buffer, then flushed
    colls <= 5'h10;
    n = ns;
    txf(2, 1'b1);
    repeat (16) foreach (frm[i]) qm.push_back(frm[i]);
    tx_irq(32'h4);
    chk(32'(ns - n), 32'h10);
    // partial mode underflow, halt, software restart
    colls <= 5'h00;
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h1);
    n = ns;
    txf(2, 1'b0);
    foreach (frm[i]) qm.push_back(frm[i]);
    tx_irq(32'h2);
    chk(32'(ns - n), 32'h1);
    txf(1, 1'b1);
    repeat (20) @(posedge i_clock);
    chk(32'(ns - n), 32'h1);
    wr(8'h00, 32'h3);
    txf(2, 1'b1);
    foreach (frm[i]) qm.push_back(frm[i]);
    tx_irq(32'h1);
    // full duplex frame, space freed as words leave
    wr(8'h00, 32'h7);
    txf(2, 1'b1);
    foreach (frm[i]) qm.push_back(frm[i]);
    tx_irq(32'h1);
    // receive path with the good-frame interrupt masked
    wr(8'h0C, 32'h37);
    rx(2, 1'b0, 2'h3);
    chk(o_irq, 32'h0);
    rx(3, 1'b1, 2'h3);
    chk(o_irq, 32'h1);
    rd(8'h08, 32'h28);
    wr(8'h00, 32'hA);
    rx(2, 1'b0, 2'h2);
    chk(32'(qm.size() + qd.size()), 32'h0);
    conclude;
  end
endmodule // epb_top_tb
`default_nettype wire
